// >>> hw/ebm_consts.vh
// Purpose: constants of the expansion bus master
// Assumes: included by ebm_master.v only
// Notes: register indices are word addresses on the slave port
`ifndef EBM_CONSTS_VH
`define EBM_CONSTS_VH
`define EBM_REG_ATTR 3'h0
`define EBM_REG_ADDR 3'h1
`define EBM_REG_DATA_HI 3'h2
`define EBM_REG_DATA_LO 3'h3
`define EBM_REG_CMD 3'h4
`define EBM_F_DW 0
`define EBM_F_BURST_EN 2
`define EBM_F_BASIC 3
`define EBM_F_BLEN 4
`define EBM_F_FIRST 8
`define EBM_F_BRD 12
`define EBM_F_BWD 16
`define EBM_ATTR_RST 32'h000fff30
`define EBM_ATTR_MASK 32'h000fff7f
`define EBM_F_CNT 0
`define EBM_F_WR 4
`define EBM_ST_BUSY 0
`define EBM_ST_DONE 1
`define EBM_MAX_BYTES 4'h8
`define EBM_DW_8 2'h0
`define EBM_DW_16 2'h1
`define EBM_DW_32 2'h2
`define EBM_DW_LEGACY 2'h3
`define EBM_MARGIN_NORM 4'h1
`define EBM_MARGIN_BASIC 4'h3
`endif

// >>> hw/ebm_master.v
// Purpose: expansion bus master, beat sequencing and lane mapping
// Assumes: host address aligned to the port width; one clock core_clk
// Notes: registers reached over avalon-mm, one wait state per access
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "ebm_consts.vh"

module ebm_master (
  input wire core_clk,
  input wire rstn,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire beat_extend_n,
  input wire legacy_data_map,
  input wire [31:0] muxed_addr_data_lines_in,
  output reg [31:0] muxed_addr_data_lines_out,
  output reg [31:0] muxed_addr_data_lines_oe,
  output reg [9:0] dedicated_address_lines,
  output reg address_latch_strobe,
  output reg chip_select_n,
  output reg read_strobe_n,
  output reg write_strobe_n
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_SETUP = 3'h2;
  localparam S_ACC = 3'h3;
  localparam S_GAP = 3'h4;
  localparam S_HOLD = 3'h5;

  // pin inputs, two flops before use
  reg ext_m, ext_s, map_m, map_s;
  reg [31:0] din_m, din_s;

  reg bus_ack;
  reg [31:0] attr, host_addr;
  reg [63:0] data_buf;
  reg [2:0] state;
  reg [3:0] cnt, beat_idx, beats_left, byte_cnt;
  reg [2:0] burst_pos;
  reg [31:0] cur_addr;
  reg is_write, busy, done;

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          be_merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction

  // bytes moved per beat
  function [3:0] beat_bytes;
    input [1:0] dw;
    input lmap;
    begin
      if (dw == `EBM_DW_8 || (dw == `EBM_DW_LEGACY && lmap))
        beat_bytes = 4'h1;
      else if (dw == `EBM_DW_32)
        beat_bytes = 4'h4;
      else
        beat_bytes = 4'h2;
    end
  endfunction

  function [3:0] beats_of;
    input [3:0] bytes;
    input [3:0] bb;
    reg [3:0] sum;
    begin
      sum = bytes + bb - 4'h1;
      if (bb == 4'h4)
        beats_of = {2'b00, sum[3:2]};
      else if (bb == 4'h2)
        beats_of = {1'b0, sum[3:1]};
      else
        beats_of = bytes;
    end
  endfunction

  function [3:0] nz;
    input [3:0] t;
    begin
      nz = (t == 4'h0) ? 4'h1 : t;
    end
  endfunction

  // dedicated lines: {xadr25, xadr24, xadr7..xadr0}
  function [9:0] ded_map;
    input [1:0] dw;
    input [31:0] a;
    begin
      case (dw)
        `EBM_DW_8: ded_map = {2'b00, a[7:0]};
        `EBM_DW_32: ded_map = {a[25], a[24], a[7:2], a[27], a[26]};
        default: ded_map = {a[25], a[24], a[7:1], a[26]};
      endcase
    end
  endfunction

  // lane of byte k of a beat; lane 0 is lines 31..24
  function [1:0] lane_of;
    input [3:0] idx;
    input [2:0] k;
    input leg;
    begin
      if (leg)
        lane_of = idx[2] ? 2'h1 : 2'h0;
      else
        lane_of = k[1:0];
    end
  endfunction

  // {lane mask, lane data} for the current beat
  function [35:0] beat_lanes;
    input [63:0] b;
    input [3:0] idx;
    input [3:0] bb;
    input leg;
    integer k;
    reg [3:0] pos;
    reg [1:0] ln;
    begin
      beat_lanes = 36'h0;
      for (k = 0; k < 4; k = k + 1) begin
        pos = idx * bb + k[3:0];
        ln = lane_of(idx, k[2:0], leg);
        if (k < bb && pos < 4'h8) begin
          beat_lanes[35 - ln] = 1'b1;
          beat_lanes[31 - 8*ln -: 8] = b[63 - 8*pos -: 8];
        end
      end
    end
  endfunction

  function [63:0] capture;
    input [63:0] b;
    input [31:0] din;
    input [3:0] idx;
    input [3:0] bb;
    input leg;
    integer k;
    reg [3:0] pos;
    reg [1:0] ln;
    begin
      capture = b;
      for (k = 0; k < 4; k = k + 1) begin
        pos = idx * bb + k[3:0];
        ln = lane_of(idx, k[2:0], leg);
        if (k < bb && pos < 4'h8)
          capture[63 - 8*pos -: 8] = din[31 - 8*ln -: 8];
      end
    end
  endfunction

  wire [1:0] dw = attr[`EBM_F_DW +: 2];
  wire legacy = (dw == `EBM_DW_LEGACY);
  wire leg_lanes = legacy & map_s;
  wire basic = attr[`EBM_F_BASIC];
  // basic mode stretches margins the same way in legacy mode
  wire [3:0] margin = basic ? `EBM_MARGIN_BASIC : `EBM_MARGIN_NORM;
  wire burst_on = attr[`EBM_F_BURST_EN] & ~basic;
  wire [2:0] blen_m1 = attr[`EBM_F_BLEN +: 3];
  wire [3:0] t_first = nz(attr[`EBM_F_FIRST +: 4]);
  wire [3:0] t_brd = nz(attr[`EBM_F_BRD +: 4]);
  wire [3:0] t_bwd = nz(attr[`EBM_F_BWD +: 4]);
  // legacy mode moves 16 bits per beat, or 8 bits when the legacy_data_map strap is set
  wire [3:0] bb = beat_bytes(dw, map_s);

  wire bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  wire wr_take = avs_write & bus_ack;
  wire [3:0] cmd_cnt = avs_writedata[`EBM_F_CNT +: 4];
  wire start = wr_take & (avs_address == `EBM_REG_CMD) & ~busy &
    (cmd_cnt != 4'h0) & (cmd_cnt <= `EBM_MAX_BYTES);
  wire cfg_wr = wr_take & ~busy;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_m <= 1'b1;
      ext_s <= 1'b1;
      map_m <= 1'b0;
      map_s <= 1'b0;
      din_m <= 32'h0;
      din_s <= 32'h0;
    end else begin
      ext_m <= beat_extend_n;
      ext_s <= ext_m;
      map_m <= legacy_data_map;
      map_s <= map_m;
      din_m <= muxed_addr_data_lines_in;
      din_s <= din_m;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read & ~bus_ack) begin
        case (avs_address)
          `EBM_REG_ATTR: avs_readdata <= attr;
          `EBM_REG_ADDR: avs_readdata <= host_addr;
          `EBM_REG_DATA_HI: avs_readdata <= data_buf[63:32];
          `EBM_REG_DATA_LO: avs_readdata <= data_buf[31:0];
          `EBM_REG_CMD: avs_readdata <= {29'h0, state == S_IDLE ?
            1'b0 : 1'b1, done, busy};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // configuration is refused while a transaction runs
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      attr <= `EBM_ATTR_RST;
      host_addr <= 32'h0;
    end else if (cfg_wr) begin
      if (avs_address == `EBM_REG_ATTR)
        attr <= be_merge(attr, avs_writedata, avs_byteenable) &
          `EBM_ATTR_MASK;
      if (avs_address == `EBM_REG_ADDR)
        host_addr <= be_merge(host_addr, avs_writedata, avs_byteenable);
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_buf <= 64'h0;
      state <= S_IDLE;
      cnt <= 4'h0;
      beat_idx <= 4'h0;
      beats_left <= 4'h0;
      byte_cnt <= 4'h0;
      burst_pos <= 3'h0;
      cur_addr <= 32'h0;
      is_write <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (cfg_wr && avs_address == `EBM_REG_DATA_HI)
            data_buf[63:32] <= be_merge(data_buf[63:32], avs_writedata,
              avs_byteenable);
          if (cfg_wr && avs_address == `EBM_REG_DATA_LO)
            data_buf[31:0] <= be_merge(data_buf[31:0], avs_writedata,
              avs_byteenable);
          if (start) begin
            cur_addr <= host_addr;
            byte_cnt <= cmd_cnt;
            is_write <= avs_writedata[`EBM_F_WR];
            beats_left <= beats_of(cmd_cnt, bb);
            beat_idx <= 4'h0;
            burst_pos <= 3'h0;
            cnt <= margin;
            busy <= 1'b1;
            done <= 1'b0;
            state <= S_ADDR;
          end
        end
        S_ADDR: begin
          cnt <= cnt - 4'h1;
          if (cnt <= 4'h1) begin
            cnt <= margin;
            state <= S_SETUP;
          end
        end
        S_SETUP: begin
          cnt <= cnt - 4'h1;
          if (cnt <= 4'h1) begin
            cnt <= t_first;
            state <= S_ACC;
          end
        end
        S_ACC: begin
          if (cnt > 4'h1)
            cnt <= cnt - 4'h1;
          else if (ext_s) begin
            if (!is_write)
              data_buf <= capture(data_buf, din_s, beat_idx, bb, leg_lanes);
            cur_addr <= cur_addr + {28'h0, bb};
            beat_idx <= beat_idx + 4'h1;
            beats_left <= beats_left - 4'h1;
            if (beats_left == 4'h1) begin
              cnt <= margin;
              state <= S_HOLD;
            end else if (burst_on && burst_pos != blen_m1) begin
              burst_pos <= burst_pos + 3'h1;
              if (is_write) begin
                cnt <= 4'h1;
                state <= S_GAP;
              end else
                cnt <= t_brd;
            end else begin
              burst_pos <= 3'h0;
              cnt <= margin;
              state <= S_HOLD;
            end
          end
        end
        S_GAP: begin
          cnt <= t_bwd;
          state <= S_ACC;
        end
        S_HOLD: begin
          cnt <= cnt - 4'h1;
          if (cnt <= 4'h1) begin
            cnt <= margin;
            if (beats_left == 4'h0) begin
              busy <= 1'b0;
              done <= 1'b1;
              state <= S_IDLE;
            end else if (basic)
              state <= S_ADDR;
            else
              state <= S_SETUP;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // pin values, registered below so the pins never glitch
  reg [31:0] p_out, p_oe, mask32;
  reg [9:0] p_ded;
  reg [35:0] ln;
  reg p_ale, p_cs_n, p_rd_n, p_wr_n;
  always @* begin
    p_out = 32'h0;
    p_oe = 32'h0;
    p_ded = 10'h0;
    p_ale = 1'b0;
    p_cs_n = 1'b1;
    p_rd_n = 1'b1;
    p_wr_n = 1'b1;
    ln = beat_lanes(data_buf, beat_idx, bb, leg_lanes);
    mask32 = {{8{ln[35]}}, {8{ln[34]}}, {8{ln[33]}}, {8{ln[32]}}};
    if (state == S_ADDR) begin
      p_cs_n = 1'b0;
      p_ale = 1'b1;
      p_oe = 32'hffffffff;
      p_out[31:24] = {~is_write, 1'b0, 2'b00, byte_cnt};
      if (legacy) begin
        p_out[6:0] = cur_addr[28:22];
        p_ded = {2'b00, cur_addr[21:15], 1'b0};
      end else begin
        p_out[23:0] = cur_addr[31:8];
        p_ded = ded_map(dw, cur_addr);
      end
    end else if (state != S_IDLE) begin
      p_cs_n = 1'b0;
      if (legacy) begin
        p_out[6:0] = cur_addr[14:8];
        p_ded = {2'b00, cur_addr[7:1], 1'b0};
      end else begin
        p_out[23:0] = cur_addr[31:8];
        p_ded = ded_map(dw, cur_addr);
      end
      p_out = (ln[31:0] & mask32) | (p_out & ~mask32);
      p_oe = is_write ? 32'hffffffff : ~mask32;
      if (state == S_ACC) begin
        p_rd_n = is_write;
        p_wr_n = ~is_write;
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      muxed_addr_data_lines_out <= 32'h0;
      muxed_addr_data_lines_oe <= 32'h0;
      dedicated_address_lines <= 10'h0;
      address_latch_strobe <= 1'b0;
      chip_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      muxed_addr_data_lines_out <= p_out;
      muxed_addr_data_lines_oe <= p_oe;
      dedicated_address_lines <= p_ded;
      address_latch_strobe <= legacy ? ~p_ale : p_ale;
      chip_select_n <= p_cs_n;
      read_strobe_n <= p_rd_n;
      write_strobe_n <= p_wr_n;
    end
  end

endmodule

// >>> dv/ebm_master_chk.sv
// Purpose: pin protocol checks for the expansion bus master
// Assumes: attribute and command words written only while idle
// Notes: mirrors the attribute, address and command words
`timescale 1ns/1ns
module ebm_master_chk (
  input wire core_clk,
  input wire rstn,
  input wire [2:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire beat_extend_n,
  input wire [31:0] muxed_addr_data_lines_out,
  input wire [31:0] muxed_addr_data_lines_oe,
  input wire address_latch_strobe,
  input wire chip_select_n,
  input wire read_strobe_n,
  input wire write_strobe_n
);
  reg [31:0] attr;
  reg [31:0] addr;
  reg [4:0] cmd;
  wire leg = attr[1:0] == 2'h3;
  // legacy mode turns the latch strobe round
  wire ale_on = address_latch_strobe ^ leg;
  wire strb = !(read_strobe_n && write_strobe_n);
  wire [31:0] rd_oe = attr[1:0] == 2'h0 ? 32'h00ffffff :
    attr[1:0] == 2'h2 ? 32'h0 : 32'h0000ffff;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      attr <= 32'h000fff30;
      addr <= 32'h0;
      cmd <= 5'h0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 3'h0)
        attr <= avs_writedata;
      if (avs_address == 3'h1)
        addr <= avs_writedata;
      if (avs_address == 3'h4)
        cmd <= avs_writedata[4:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_addr_short;
    ale_on ##1 !ale_on;
  endsequence
  sequence s_addr_long;
    ale_on [*3] ##1 !ale_on;
  endsequence
  a_ale_short: assert property (
    $fell(chip_select_n) && !attr[3] |-> s_addr_short)
    else $error("short address phase wrong");
  a_ale_long: assert property (
    $fell(chip_select_n) && attr[3] |-> s_addr_long)
    else $error("basic address phase wrong");
  a_ale_once: assert property (
    $rose(ale_on) && !chip_select_n && !attr[3] |-> $fell(chip_select_n))
    else $error("second address phase");
  a_no_strobe_addr: assert property (ale_on |-> !strb)
    else $error("strobe during address phase");
  a_addr_bits: assert property (
    $fell(chip_select_n) && !leg |->
    muxed_addr_data_lines_out[31] == !cmd[4] &&
    muxed_addr_data_lines_out[29:0] == {2'h0, cmd[3:0], addr[31:8]})
    else $error("address phase lines wrong");
  a_read_lanes: assert property (
    !read_strobe_n |-> muxed_addr_data_lines_oe == rd_oe)
    else $error("read lane enables wrong");
  a_write_drive: assert property (
    !write_strobe_n |-> muxed_addr_data_lines_oe == 32'hffffffff)
    else $error("write lanes not driven");
  // a strobe held across beats would show the next beat's lanes
  a_wr_regen: assert property (
    !write_strobe_n && !$past(write_strobe_n) |->
    $stable(muxed_addr_data_lines_out))
    else $error("write strobe not regenerated");
  a_strobe_excl: assert property (!(!read_strobe_n && !write_strobe_n))
    else $error("read and write strobe together");
  a_leg_addr: assert property (
    $fell(chip_select_n) && leg |->
    muxed_addr_data_lines_out[6:0] == addr[28:22])
    else $error("legacy address phase wrong");
  a_extend_hold: assert property (
    !beat_extend_n [*4] ##0 strb |=> strb)
    else $error("beat ended while extended");
endmodule
bind ebm_master ebm_master_chk u_chk (.core_clk, .rstn, .avs_address,
  .avs_write, .avs_writedata, .avs_waitrequest, .beat_extend_n,
  .muxed_addr_data_lines_out, .muxed_addr_data_lines_oe,
  .address_latch_strobe, .chip_select_n, .read_strobe_n,
  .write_strobe_n);

// >>> dv/ebm_dev.sv
// Purpose: model of an addressed device on the expansion bus
// Assumes: small aligned addresses, low byte on dedicated lines
// Notes: reads return each lane's byte address; writes are logged
`timescale 1ns/1ns
module ebm_dev (
  input wire core_clk,
  input wire stall,
  input wire [9:0] dedicated_address_lines,
  input wire [31:0] muxed_addr_data_lines_out,
  input wire read_strobe_n,
  input wire write_strobe_n,
  output wire [31:0] muxed_addr_data_lines_in,
  output reg beat_extend_n
);
  wire [7:0] d = dedicated_address_lines[7:0];
  reg [31:0] keep = 32'h0;
  reg [3:0] lo_cnt = 4'h0;
  reg wr_q = 1'b1;
  reg [41:0] last = 42'h0;
  reg [41:0] log[$];
  // released lines toggle so no stale value can pass for data
  assign muxed_addr_data_lines_in = read_strobe_n ? ~keep :
    {d, d | 8'h01, d | 8'h02, d | 8'h03};
  initial beat_extend_n = 1'b1;
  always @(posedge core_clk) begin
    keep <= muxed_addr_data_lines_in;
    wr_q <= write_strobe_n;
    if (read_strobe_n && write_strobe_n)
      lo_cnt <= 4'h0;
    else if (lo_cnt != 4'hf)
      lo_cnt <= lo_cnt + 4'h1;
    beat_extend_n <= !(stall && lo_cnt < 4'h5 &&
      !(read_strobe_n && write_strobe_n));
    if (!write_strobe_n)
      last <= {dedicated_address_lines, muxed_addr_data_lines_out};
    if (write_strobe_n && !wr_q)
      log.push_back(last);
  end
endmodule

// >>> dv/test_expansion_bus_master_beats_lanes.sv
// Purpose: directed tests of the expansion bus master
// Assumes: device model answers reads with its own address bytes
// Notes: access times kept short so the run stays brief
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module test_expansion_bus_master_beats_lanes;
  logic core_clk = 0;
  logic rstn = 0;
  logic [2:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic legacy_data_map = 0;
  logic stall = 0;
  wire [31:0] rdata, mx_in, mx_out;
  wire wreq, ext_n, wr_n, rd_n;
  wire [9:0] ded;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [41:0] e;
  always #5 core_clk = ~core_clk;
  ebm_master u_ebm_master (.core_clk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .beat_extend_n(ext_n),
    .legacy_data_map, .muxed_addr_data_lines_in(mx_in),
    .muxed_addr_data_lines_out(mx_out), .muxed_addr_data_lines_oe(),
    .dedicated_address_lines(ded), .address_latch_strobe(),
    .chip_select_n(), .read_strobe_n(rd_n), .write_strobe_n(wr_n));
  ebm_dev u_ebm_dev (.core_clk, .stall, .dedicated_address_lines(ded),
    .muxed_addr_data_lines_out(mx_out), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .muxed_addr_data_lines_in(mx_in),
    .beat_extend_n(ext_n));
  task automatic close_out;
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic bus(input logic w, input logic [2:0] a,
      input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (wreq !== 1'b0);
    q = rdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  // poll until done is set and busy is clear
  task automatic xfer(input logic [31:0] at, input logic [31:0] ad,
      input logic [4:0] c);
    int i;
    u_ebm_dev.log.delete();
    bus(1, 3'h0, at);
    bus(1, 3'h1, ad);
    bus(1, 3'h4, {27'h0, c});
    for (i = 0; i < 300; i++) begin
      bus(0, 3'h4, 0);
      if (q[1:0] === 2'b10)
        break;
    end
    `CHK("done", 2'b10, q[1:0])
  endtask
  // reads overwrite the data words, so reload before a write test that follows a read
  task automatic fill;
    bus(1, 3'h2, 32'ha1b2c3d4);
    bus(1, 3'h3, 32'h5a6b7c8d);
  endtask
  task automatic ent(input int i, input logic [7:0] ad,
      input logic [31:0] m, input logic [31:0] v);
    e = u_ebm_dev.log[i];
    `CHK("beat addr", ad, e[39:32])
    `CHK("beat data", v & m, e[31:0] & m)
  endtask
  task automatic rd2(input logic [31:0] hi, input logic [31:0] lo);
    bus(0, 3'h2, 0);
    `CHK("data hi", hi, q)
    bus(0, 3'h3, 0);
    `CHK("data lo", lo, q)
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1;
    bus(0, 3'h0, 0);
    `CHK("attr reset", 32'h000fff30, q)
    fill;
    xfer(32'h00024634, 32'h40, 5'h12);
    `CHK("beats", 2, u_ebm_dev.log.size())
    ent(0, 8'h40, 32'hff000000, 32'ha1000000);
    ent(1, 8'h41, 32'hffffffff, 32'hb2000000);
    xfer(32'h00024631, 32'h40, 5'h14);
    `CHK("beats", 2, u_ebm_dev.log.size())
    ent(0, 8'h40, 32'hffffffff, 32'ha1b20000);
    ent(1, 8'h42, 32'hffffffff, 32'hc3d40000);
    xfer(32'h00024636, 32'h20, 5'h08);
    rd2(32'h20212223, 32'h24252627);
    stall <= 1;
    xfer(32'h00024634, 32'h30, 5'h08);
    stall <= 0;
    rd2(32'h30313233, 32'h34353637);
    xfer(32'h0002463d, 32'h10, 5'h04);
    bus(0, 3'h2, 0);
    `CHK("basic read", 32'h10111213, q)
    fill;
    xfer(32'h00024637, 32'h10400040, 5'h12);
    `CHK("beats", 1, u_ebm_dev.log.size())
    ent(0, 8'h40, 32'hffff0000, 32'ha1b20000);
    xfer(32'h0002463f, 32'h50, 5'h02);
    bus(0, 3'h2, 0);
    `CHK("legacy read", 32'h5051, q[31:16])
    legacy_data_map <= 1;
    repeat (3) @(posedge core_clk);
    fill;
    xfer(32'h00024637, 32'h0, 5'h18);
    `CHK("beats", 8, u_ebm_dev.log.size())
    for (int i = 0; i < 8; i++) begin
      e = u_ebm_dev.log[i];
      q = {24'h0, 8'((64'ha1b2c3d45a6b7c8d >> (56 - 8 * i)))};
      q = i < 4 ? q << 24 : q << 16;
      `CHK("lane", q, e[31:0] & (i < 4 ? 32'hff000000 : 32'h00ff0000))
    end
    close_out;
  end
endmodule
